// >>> hw/vdc_pkg.sv
// Shared constants and types for the four-channel voltage converter control.
// Assumes a 32-bit AHB-Lite fabric and a single core clock.
package vdc_pkg;

  localparam int VDC_NUM = 4;
  localparam int VDC_CODE_W = 12;

  // Byte addresses of the control and data registers, channel 3 first
  localparam logic [3:0][31:0] VDC_CTL_ADDR = {
    32'hFFFF05D8, 32'hFFFF05B0, 32'hFFFF0588, 32'hFFFF0580};
  localparam logic [3:0][31:0] VDC_DAT_ADDR = {
    32'hFFFF05DC, 32'h0FFF05B4, 32'hFFFF058C, 32'hFFFF0584};

  localparam logic [15:0] VDC_CTL_RESET = 16'h0100;
  localparam logic [31:0] VDC_DAT_RESET = 32'h00000000;
  localparam logic [15:0] VDC_CTL_WMASK = 16'h01FF;

  // Control field positions
  localparam int VDC_PD_BIT = 8;
  localparam int VDC_LP_BIT = 7;
  localparam int VDC_SKIP_BIT = 6;
  localparam int VDC_UPD_BIT = 5;
  localparam int VDC_CLR_BIT = 4;
  localparam int VDC_MODE_BIT = 3;
  localparam int VDC_RATE_BIT = 2;
  localparam int VDC_RANGE_LSB = 0;

  // Data field positions
  localparam int VDC_CODE_MSB = 27;
  localparam int VDC_CODE_LSB = 16;
  localparam int VDC_FRAC_MSB = 15;
  localparam int VDC_FRAC_LSB = 12;

  // Interpolation clock dividers
  localparam int VDC_DIV_FAST = 16;
  localparam int VDC_DIV_SLOW = 32;
  localparam logic [4:0] VDC_DIV_FAST_LAST = 5'(VDC_DIV_FAST - 1);
  localparam logic [4:0] VDC_DIV_SLOW_LAST = 5'(VDC_DIV_SLOW - 1);

  localparam logic [2:0] VDC_HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic [6:0] rsvd;
    logic power_down;
    logic buf_low_power;
    logic buf_skip;
    logic update_source;
    logic data_clear_n;
    logic normal_mode;
    logic rate_fast;
    logic [1:0] range;
  } vdc_ctrl_t;

  typedef struct packed {
    logic [VDC_CODE_W-1:0] code;
    logic drive_en;
    logic buf_low_power;
    logic buf_skip;
    logic [1:0] range;
  } vdc_out_t;

  typedef struct packed {
    logic write;
    logic [VDC_NUM-1:0] ctl;
    logic [VDC_NUM-1:0] dat;
  } vdc_req_t;

endpackage : vdc_pkg

// >>> hw/vdc_channel.sv
// One converter channel: update timing, interpolator and output drive.
// Assumes control and data come from flops on the same clock.
`timescale 1ns/1ps
`default_nettype none

module vdc_channel
  import vdc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire vdc_ctrl_t ctrl,
  input wire logic [31:0] data,
  input wire logic timer_one_evt,
  output wire vdc_out_t out
);

  wire logic update_now;
  wire logic tick;
  wire logic [4:0] div_last;
  wire logic [4:0] div_d;
  wire logic [4:0] acc_sum;
  wire logic [3:0] acc_d;
  wire logic [15:0] target_d;
  wire logic [11:0] code_base;
  wire logic [11:0] code_up;
  wire logic [11:0] code_d;
  logic [15:0] target_q;
  logic [4:0] div_q;
  logic [3:0] acc_q;
  logic [11:0] code_q;

  assign update_now = ctrl.update_source ? timer_one_evt : 1'b1;
  assign target_d = update_now ?
    {data[VDC_CODE_MSB:VDC_CODE_LSB],
     data[VDC_FRAC_MSB:VDC_FRAC_LSB]} : target_q;

  // Divider is held at zero in normal mode
  assign div_last = ctrl.rate_fast ?
    VDC_DIV_FAST_LAST : VDC_DIV_SLOW_LAST;
  assign tick = !ctrl.normal_mode && (div_q >= div_last);
  assign div_d = (ctrl.normal_mode || tick) ? 5'h00 : div_q + 5'h01;

  // Fraction accumulates per tick; its carry lifts the code by one, except at 0xFFF where it holds
  assign acc_sum = {1'b0, acc_q} + {1'b0, target_q[3:0]};
  assign acc_d = ctrl.normal_mode ? 4'h0 : (tick ? acc_sum[3:0] : acc_q);
  assign code_base = target_q[15:4];
  assign code_up = (acc_sum[4] && code_base != 12'hFFF) ?
    code_base + 12'h001 : code_base;
  assign code_d = ctrl.normal_mode ? code_base :
    (tick ? code_up : code_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      target_q <= 16'h0000;
      div_q <= 5'h00;
      acc_q <= 4'h0;
      code_q <= 12'h000;
    end else begin
      target_q <= target_d;
      div_q <= div_d;
      acc_q <= acc_d;
      code_q <= code_d;
    end
  end

  assign out = '{code: code_q,
                 drive_en: !ctrl.power_down,
                 buf_low_power: ctrl.buf_low_power,
                 buf_skip: ctrl.buf_skip,
                 range: ctrl.range};

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_core_rate;
    !ctrl.update_source && ctrl.normal_mode;
  endsequence

  AST_CORE_UPDATE: assert property (
    s_core_rate ##1 s_core_rate |=> code_q == $past(data[27:16], 2))
    else $error("core-clock update did not reach the code");
  AST_TIMER_HOLD: assert property (
    ctrl.update_source && !timer_one_evt |=> $stable(target_q))
    else $error("target moved without a timer event");
  AST_NORMAL_STOP: assert property (
    ctrl.normal_mode |=> div_q == 5'h00 && acc_q == 4'h0)
    else $error("interpolator clock runs in normal mode");
  AST_RATE: assert property (
    tick |-> $changed(ctrl.rate_fast)
      || div_q == (ctrl.rate_fast ? 5'h0F : 5'h1F))
    else $error("interpolation tick at wrong divide");
  AST_FRAC_IGNORED: assert property (
    ctrl.normal_mode |=> code_q == $past(target_q[15:4]))
    else $error("fraction used in normal mode");

endmodule : vdc_channel

`default_nettype wire

// >>> hw/vdc_voltage_dac_control.sv
// Register file and AHB-Lite slave for four voltage converter channels.
// Assumes one AHB-Lite master, word transfers, and a timer event pulse
// generated on the same core clock.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Four independent 12-bit converters, each with own control and data.
// - Power-down bit set powers the converter down and tristates its pin.
// - Control registers reset to 0x100 and are software read/write.
// - Low-power bit puts the output buffer amplifier in low power.
// - Buffer-skip bit routes the output around the buffer.
// - Update-source bit picks timer-one event or core clock for updates.
// - While data-clear bit is clear, the data register is held at zero.
// - Mode bit set gives normal mode and stops the interpolator clock.
// - Rate bit set gives core clock over 16, clear over 32.
// - Two-bit range field selects output span, passed to the analog side.
// - Data registers reset to zero and are software read/write.
// - The output code is taken from data bits 27:16.
// - Data bits 15:12 are extra fraction, used only when interpolating.
module vdc_voltage_dac_control
  import vdc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic timer_one_evt,
  output wire vdc_out_t [VDC_NUM-1:0] analog_out
);

  wire logic ap_take;
  wire logic ap_word;
  wire logic [VDC_NUM-1:0] ctl_hit;
  wire logic [VDC_NUM-1:0] dat_hit;
  wire logic [VDC_NUM-1:0] wr_ctl;
  wire logic [VDC_NUM-1:0] wr_dat;
  wire vdc_req_t req_d;
  vdc_req_t req_q;
  vdc_ctrl_t ctl_d [VDC_NUM];
  vdc_ctrl_t ctl_q [VDC_NUM];
  logic [31:0] dat_d [VDC_NUM];
  logic [31:0] dat_q [VDC_NUM];
  logic [31:0] rd_mux;

  // Address phase: a transfer is taken when selected, active and ready
  assign ap_take = hsel && htrans[1] && hready;
  assign ap_word = hsize == VDC_HSIZE_WORD;

  // Unmapped addresses decode to nothing: reads give zero, writes drop
  assign req_d = ap_take ?
    '{write: hwrite && ap_word, ctl: ctl_hit, dat: dat_hit} : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else if (hready) begin
      req_q <= req_d;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < VDC_NUM; gi++) begin : g_ch
      assign ctl_hit[gi] = haddr == VDC_CTL_ADDR[gi];
      assign dat_hit[gi] = haddr == VDC_DAT_ADDR[gi];
      assign wr_ctl[gi] = req_q.write && req_q.ctl[gi];
      assign wr_dat[gi] = req_q.write && req_q.dat[gi];

      // Reserved control bits are masked off on write
      always_comb begin
        ctl_d[gi] = ctl_q[gi];
        if (wr_ctl[gi]) begin
          ctl_d[gi] = vdc_ctrl_t'(hwdata[15:0] & VDC_CTL_WMASK);
        end
      end

      // Data clear dominates any write in the same cycle
      always_comb begin
        dat_d[gi] = dat_q[gi];
        if (!ctl_q[gi].data_clear_n) begin
          dat_d[gi] = VDC_DAT_RESET;
        end else if (wr_dat[gi]) begin
          dat_d[gi] = hwdata;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ctl_q[gi] <= vdc_ctrl_t'(VDC_CTL_RESET);
          dat_q[gi] <= VDC_DAT_RESET;
        end else begin
          ctl_q[gi] <= ctl_d[gi];
          dat_q[gi] <= dat_d[gi];
        end
      end

      vdc_channel u_channel (
        .hclk(hclk),
        .hresetn(hresetn),
        .ctrl(ctl_q[gi]),
        .data(dat_q[gi]),
        .timer_one_evt(timer_one_evt),
        .out(analog_out[gi])
      );
    end
  endgenerate

  // Read data selected in the data phase from the register flops
  always_comb begin
    rd_mux = 32'h00000000;
    for (int i = 0; i < VDC_NUM; i++) begin
      if (req_q.ctl[i]) begin
        rd_mux = rd_mux | {16'h0000, ctl_q[i]};
      end
      if (req_q.dat[i]) begin
        rd_mux = rd_mux | dat_q[i];
      end
    end
  end

  assign hrdata = (req_q.write) ? 32'h00000000 : rd_mux;

  // Checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_write_dat1;
    ap_take && hwrite && ap_word && haddr == VDC_DAT_ADDR[1];
  endsequence

  sequence s_enabled1;
    ctl_q[1].data_clear_n;
  endsequence

  AST_CTL_RESET: assert property (disable iff (1'b0)
    $rose(hresetn) |-> ctl_q[0] == vdc_ctrl_t'(VDC_CTL_RESET)
      && ctl_q[3] == vdc_ctrl_t'(VDC_CTL_RESET))
    else $error("control register not at reset value");

  AST_DAT_RESET: assert property (disable iff (1'b0)
    $rose(hresetn) |-> dat_q[2] == VDC_DAT_RESET)
    else $error("data register not zero after reset");

  AST_PD_TRISTATE: assert property (
    ctl_q[0].power_down |-> !analog_out[0].drive_en)
    else $error("powered-down converter still drives its pin");

  AST_PD_WRITE: assert property (
    wr_ctl[2] && hwdata[VDC_PD_BIT] |=> ##1 !analog_out[2].drive_en)
    else $error("power-down write did not tristate the pin");

  AST_LOW_POWER: assert property (
    wr_ctl[1] |=> analog_out[1].buf_low_power == $past(hwdata[VDC_LP_BIT]))
    else $error("low-power bit not reaching the buffer");

  AST_SKIP: assert property (
    wr_ctl[3] |=> analog_out[3].buf_skip == $past(hwdata[VDC_SKIP_BIT]))
    else $error("buffer-skip bit not reaching the output");

  AST_CLEAR_HOLD: assert property (
    !ctl_q[0].data_clear_n |=> dat_q[0] == 32'h00000000)
    else $error("data register not held at zero while cleared");

  AST_DAT_WRITE: assert property (
    s_write_dat1 ##1 s_enabled1 |=> dat_q[1] == $past(hwdata))
    else $error("data write not stored");

  AST_RANGE: assert property (
    wr_ctl[0] |=> analog_out[0].range == $past(hwdata[1:0]))
    else $error("range field not passed to the output");

  AST_RSVD_ZERO: assert property (
    req_q.ctl[2] && !req_q.write |-> hrdata[31:9] == 23'h000000)
    else $error("reserved control bits read non-zero");

  AST_RD_DATA: assert property (
    req_q.dat[3] && !req_q.write |-> hrdata == dat_q[3])
    else $error("data register read mismatch");

  AST_CODE_SOURCE: assert property (
    ctl_q[1].normal_mode && !ctl_q[1].update_source
      && $stable(dat_q[1]) && $stable(ctl_q[1])
      |=> ##1 analog_out[1].code == $past(dat_q[1][27:16], 2))
    else $error("output code not from bits 27:16");

  AST_ALWAYS_OKAY: assert property (
    hreadyout && !hresp)
    else $error("slave answered with wait or error");

endmodule : vdc_voltage_dac_control

`default_nettype wire

// >>> bench/vdc_voltage_dac_control_tb.sv
// Self-checking bench for the four-channel converter control block.
// Assumes the design answers AHB-Lite and ties hready to hreadyout.
`timescale 1ns/1ps
`default_nettype none

module vdc_voltage_dac_control_tb;
  import vdc_pkg::*;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic timer_one_evt = 1'b0;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire vdc_out_t [VDC_NUM-1:0] analog_out;
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 9530;
  logic [31:0] w, d, d2;
  int div_n;
  int hits;

  vdc_voltage_dac_control u_dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .timer_one_evt(timer_one_evt),
    .analog_out(analog_out)
  );

  initial begin
    forever #50 hclk = ~hclk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask : chk

  // One single transfer; read data taken at the edge ending the data phase
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, input logic [2:0] sz,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    hsize <= sz;
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] r;
    bus(1'b1, a, v, VDC_HSIZE_WORD, r);
  endtask : wr

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, VDC_HSIZE_WORD, r);
    chk(r, exp);
  endtask : rchk

  function automatic logic [31:0] exp_out(input logic [31:0] c,
                                          input logic [11:0] code);
    vdc_out_t o;
    o.code = code;
    o.drive_en = ~c[8];
    o.buf_low_power = c[7];
    o.buf_skip = c[6];
    o.range = c[1:0];
    return 32'(o);
  endfunction : exp_out

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < VDC_NUM; i++) begin
      rchk(VDC_CTL_ADDR[i], 32'h100);
      rchk(VDC_DAT_ADDR[i], 32'h0);
      chk(32'(analog_out[i]), exp_out(32'h100, 12'h0));
    end
    $display("test reset_values done");
    for (int i = 0; i < VDC_NUM; i++) begin
      w = $random(seed);
      w = (w & ~32'h13F) | 32'h18 | 32'(i);
      wr(VDC_CTL_ADDR[i], w);
      rchk(VDC_CTL_ADDR[i], w & 32'h1FF);
      d = $random(seed);
      wr(VDC_DAT_ADDR[i], d);
      rchk(VDC_DAT_ADDR[i], d);
      repeat (4) @(posedge hclk);
      chk(32'(analog_out[i]), exp_out(w, d[27:16]));
      wr(VDC_CTL_ADDR[i], w | 32'h20);
      d2 = $random(seed);
      wr(VDC_DAT_ADDR[i], d2);
      repeat (6) @(posedge hclk);
      chk(32'(analog_out[i]), exp_out(w, d[27:16]));
      timer_one_evt <= 1'b1;
      @(posedge hclk);
      timer_one_evt <= 1'b0;
      repeat (3) @(posedge hclk);
      chk(32'(analog_out[i]), exp_out(w, d2[27:16]));
      wr(VDC_CTL_ADDR[i], w & ~32'h18);
      rchk(VDC_DAT_ADDR[i], 32'h0);
      wr(VDC_DAT_ADDR[i], d);
      rchk(VDC_DAT_ADDR[i], 32'h0);
      w = (w & ~32'h8) | {29'h0, i[0], 2'h0};
      wr(VDC_CTL_ADDR[i], w);
      wr(VDC_DAT_ADDR[i], d & 32'hFFFF0FFF);
      repeat (70) @(posedge hclk);
      chk(32'(analog_out[i]), exp_out(w, d[27:16]));
      // Half fraction: code sits one step up for every other tick period
      d = (d & 32'hFFFE0FFF) | 32'h00008000;
      wr(VDC_DAT_ADDR[i], d);
      div_n = i[0] ? VDC_DIV_FAST : VDC_DIV_SLOW;
      repeat (2 * div_n) @(posedge hclk);
      hits = 0;
      repeat (4 * div_n) begin
        @(posedge hclk);
        if (analog_out[i].code == d[27:16] + 12'h001) begin
          hits++;
        end
      end
      chk(hits, 2 * div_n);
      wr(VDC_CTL_ADDR[i], w | 32'h100);
      @(posedge hclk);
      chk({31'h0, analog_out[i].drive_en}, 32'h0);
      $display("test channel %0d done", i);
    end
    rchk(32'hFFFF0590, 32'h0);
    wr(VDC_CTL_ADDR[0], 32'hFFFFFFD8);
    bus(1'b1, VDC_CTL_ADDR[0], 32'h0, 3'h0, w);
    rchk(VDC_CTL_ADDR[0], 32'h1D8);
    $display("test refused_access done");
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    $display("watchdog expired");
    stop_test();
  end

endmodule : vdc_voltage_dac_control_tb

`default_nettype wire
